// file: inc/vgdr_pkg.sv
// Constants, field layouts and carrier types for the diagnostic and identification registers
package vgdr_pkg;
  localparam int NODES = 6;
  localparam int FRAME_BITS = 16;
  localparam logic [3:0] LAST_BIT = 4'(FRAME_BITS - 1);

  // Register addresses, even byte of each 16-bit register
  localparam logic [6:0] A_PAGE = 7'h00;
  localparam logic [6:0] A_FLASH_CNT = 7'h04;
  localparam logic [6:0] A_GW_PROD = 7'h16;
  localparam logic [6:0] A_GW_LOT_LO = 7'h1A;
  localparam logic [6:0] A_GW_LOT_HI = 7'h1C;
  localparam logic [6:0] A_GW_SERIAL = 7'h24;
  localparam logic [6:0] A_OUT_CTRL = 7'h2A;
  localparam logic [6:0] A_GW_DIAG = 7'h2C;
  localparam logic [6:0] A_NODE_DIAG = 7'h34;
  localparam logic [6:0] A_GLOB_CMD = 7'h36;
  localparam logic [6:0] A_NODE_PROD = 7'h48;
  localparam logic [6:0] A_NODE_SCR = 7'h64;
  localparam logic [6:0] A_NODE_LOT_LO = 7'h68;
  localparam logic [6:0] A_NODE_LOT_HI = 7'h6A;
  localparam logic [7:0] PAGE_GW = 8'h00;

  // Product codes: arbitrary values
  localparam logic [15:0] GW_PROD_CODE = 16'h0A01;
  localparam logic [15:0] NODE_PROD_CODE = 16'h0A02;

  // Reset values and implemented-bit masks
  localparam logic [15:0] OUT_CTRL_RST = 16'h0008;
  localparam logic [15:0] OUT_CTRL_MASK = 16'h003F;
  localparam logic [15:0] GW_DIAG_MASK = 16'h7FCF;
  localparam logic [15:0] NODE_DIAG_MASK = 16'h5B77;
  localparam logic [15:0] NODE_LATCH_MASK = 16'h007F;
  localparam logic [15:0] NODE_ALM_MASK = 16'h1B00;
  localparam logic PIN_IDLE = 1'b1;
  localparam logic [2:0] CS_IDLE = 3'h7;

  // Status bit positions
  localparam int B_SYS_ALARM = 14;
  localparam int B_ALM2_Y = 12;
  localparam int B_ALM2_X = 11;
  localparam int B_ALM1_Y = 9;
  localparam int B_ALM1_X = 8;
  localparam int B_NEW_DATA = 8;
  localparam int B_CMD_DONE = 7;
  localparam int B_FLASH_FAIL = 6;
  localparam int B_SELFTEST = 5;
  localparam int B_REC_INTR = 4;
  localparam int B_SPI_ERR = 3;
  localparam int B_FLASH_UPD = 2;
  localparam int B_SUP_HI = 1;
  localparam int B_SUP_LO = 0;

  // Command bits and output control fields
  localparam int CMD_SELF_TEST = 2;
  localparam int CMD_CLR_DIAG = 4;
  localparam int CMD_FLASH_TEST = 5;
  localparam int OC_POL_A = 0;
  localparam int OC_POL_B = 1;
  localparam int OC_FN_A = 2;
  localparam int OC_FN_B = 4;

  // Supply thresholds at 440 uV per code
  localparam int SUP_LSB_UV = 440;
  localparam int SUP_HI_UV = 3625000;
  localparam int SUP_LO_UV = 2000000;
  localparam logic [15:0] SUP_HI_CODE = 16'(SUP_HI_UV / SUP_LSB_UV);
  localparam logic [15:0] SUP_LO_CODE = 16'((SUP_LO_UV + SUP_LSB_UV - 1) / SUP_LSB_UV);

  typedef enum logic [1:0] {
    FN_GP = 2'h0,
    FN_ALARM = 2'h1,
    FN_BUSY = 2'h2,
    FN_NONE = 2'h3
  } vgdr_out_fn_t;

  typedef struct packed {
    logic rw;
    logic [5:0] waddr;
    logic hi;
    logic [7:0] data;
  } vgdr_word_t;

  typedef struct packed {
    logic [15:0] lot_lo;
    logic [15:0] lot_hi;
    logic [15:0] serial;
    logic [15:0] supply;
    logic sys_alarm;
    logic ck_fail;
    logic flash_upd_fail;
    logic flash_wr;
    logic busy;
    logic [1:0] gp_level;
  } vgdr_gw_in_t;

  typedef struct packed {
    logic [15:0] lot_lo;
    logic [15:0] lot_hi;
    logic [15:0] supply;
    logic alm_latch_en;
    logic alm_x1;
    logic alm_y1;
    logic alm_x2;
    logic alm_y2;
    logic sys_alarm;
    logic rec_intr;
    logic flash_upd_fail;
    logic flash_wr;
    logic new_data;
    logic cmd_done;
    logic st_fail;
    logic ck_fail;
  } vgdr_node_in_t;

  typedef struct packed {
    logic [15:0] diag;
    logic [15:0] cmd;
    logic [15:0] scr;
    logic [15:0] fcnt;
  } vgdr_node_reg_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [14:0] sh;
  } vgdr_link_t;

  typedef struct packed {
    vgdr_word_t word;
    logic tog;
    logic partial;
  } vgdr_link_word_t;

  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] tog_sync;
    logic [1:0] part_sync;
    logic [7:0] page;
    logic [15:0] rd;
    logic [15:0] out_ctrl;
    logic [15:0] gw_diag;
    logic [15:0] gw_fcnt;
    vgdr_node_reg_t [NODES-1:0] node;
    logic do_a;
    logic do_b;
  } vgdr_sys_t;
endpackage : vgdr_pkg

// file: src/vgdr_regs.sv
// Gateway and node diagnostic, identification and output control registers
// Overview of operation
// [RQ1] Output function select and polarity per pin
// [RQ2] Output control resets to 0x0008
// [RQ3] Flags coexist; set again while condition persists
// [RQ4] Node low flags latch until clear command
// [RQ5] Node alarm flags latch only when enabled
// [RQ6] Gateway bits 8-13 flag node new data
// [RQ7] Gateway bit 7 flags command completion
// [RQ8] Bit 14 flags system alarm
// [RQ9] Gateway bit 3 flags bad clock count
// [RQ10] Bits 1/0 flag supply high/low
// [RQ11] Checksum command reports flash failure bit
// [RQ12] Self-test command reports into bit 5
// [RQ13] Node alarm and record-interrupt bit positions
// [RQ14] Flash write counters increment per write
// [RQ15] Node scratch register, writable, resets zero
// [RQ16] Read-only lot, serial and product words
// [RQ17] Page 0 gateway, pages 1-6 nodes
// [RQ18] Command bits self-clear when done
// [RQ19] Unused bits read zero, ignore writes; the node command register stores and reads back unused bits written to it
`timescale 1ns/1ps
module vgdr_regs (
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Serial link
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe,
  // Gateway and node status sources
  input wire vgdr_pkg::vgdr_gw_in_t i_gw,
  input wire vgdr_pkg::vgdr_node_in_t [vgdr_pkg::NODES-1:0] i_node,
  // Node commands and digital outputs
  output logic [vgdr_pkg::NODES-1:0][15:0] o_node_cmd,
  output logic o_digital_out_a,
  output logic o_digital_out_b
);

  vgdr_pkg::vgdr_link_t lf_r;
  vgdr_pkg::vgdr_link_t lf_nxt;
  vgdr_pkg::vgdr_link_word_t lw_r;
  vgdr_pkg::vgdr_link_word_t lw_nxt;
  logic [15:0] tx_r;
  vgdr_pkg::vgdr_sys_t s_r;
  vgdr_pkg::vgdr_sys_t s_nxt;

  logic word_ev;
  logic frame_end;
  logic is_wr;
  logic is_rd;
  logic [6:0] addr;
  logic [15:0] wbits;
  logic [15:0] rdv;
  logic [15:0] gset;
  logic [15:0] cnd;
  logic [15:0] keep;
  logic [15:0] nd;
  logic [15:0] cmdv;
  logic any_done;
  logic any_alarm;
  logic node_wr;

  // Link domain: counter restarts with every frame
  always_comb
  begin
    lf_nxt.cnt = lf_r.cnt + 4'h1;
    lf_nxt.sh = {lf_r.sh[13:0], i_din};
  end

  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      lf_r <= '0;
    else
      lf_r <= lf_nxt;
  end

  // Held across frames so the system side can judge a frame after it ends
  always_comb
  begin
    lw_nxt = lw_r;
    lw_nxt.partial = (lf_r.cnt != vgdr_pkg::LAST_BIT); // see [RQ9]
    if (lf_r.cnt == vgdr_pkg::LAST_BIT)
    begin
      lw_nxt.word = vgdr_pkg::vgdr_word_t'({lf_r.sh, i_din});
      lw_nxt.tog = ~lw_r.tog;
    end
  end

  always_ff @(posedge i_sclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      lw_r <= '0;
    else
      lw_r <= lw_nxt;
  end

  // Reply word is quasi-static: it only changes a few cycles after a word ends
  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
      tx_r <= '0;
    else if (lf_r.cnt == '0)
      tx_r <= s_r.rd;
    else
      tx_r <= {tx_r[14:0], 1'b0};
  end

  assign o_dout = tx_r[15];
  assign o_dout_oe = ~i_cs_n;

  // System domain decode of a received word
  assign word_ev = s_r.tog_sync[2] ^ s_r.tog_sync[1];
  assign frame_end = s_r.cs_sync[1] & ~s_r.cs_sync[2];
  assign is_wr = word_ev & lw_r.word.rw;
  assign is_rd = word_ev & ~lw_r.word.rw;
  assign addr = {lw_r.word.waddr, 1'b0};
  assign wbits = lw_r.word.hi ? {lw_r.word.data, 8'h00} : {8'h00, lw_r.word.data};

  function automatic logic [15:0] merge(input logic [15:0] old, input vgdr_pkg::vgdr_word_t w);
    return w.hi ? {w.data, old[7:0]} : {old[15:8], w.data};
  endfunction : merge

  function automatic logic pin_level(input logic [1:0] fn, input logic pol,
                                     input logic gp, input logic alm, input logic busy);
    logic act;
    act = 1'b0;
    unique case (vgdr_pkg::vgdr_out_fn_t'(fn))
      vgdr_pkg::FN_GP: act = gp;
      vgdr_pkg::FN_ALARM: act = alm;
      vgdr_pkg::FN_BUSY: act = busy;
      vgdr_pkg::FN_NONE: act = 1'b0;
    endcase
    return pol ? act : ~act;
  endfunction : pin_level

  // Read multiplexer
  always_comb
  begin
    rdv = '0;
    if (s_r.page == vgdr_pkg::PAGE_GW) // see [RQ17]
    begin
      case (addr)
        vgdr_pkg::A_PAGE: rdv = {8'h00, s_r.page};
        vgdr_pkg::A_FLASH_CNT: rdv = s_r.gw_fcnt;
        vgdr_pkg::A_GW_PROD: rdv = vgdr_pkg::GW_PROD_CODE; // see [RQ16]
        vgdr_pkg::A_GW_LOT_LO: rdv = i_gw.lot_lo;
        vgdr_pkg::A_GW_LOT_HI: rdv = i_gw.lot_hi;
        vgdr_pkg::A_GW_SERIAL: rdv = i_gw.serial;
        vgdr_pkg::A_OUT_CTRL: rdv = s_r.out_ctrl;
        vgdr_pkg::A_GW_DIAG: rdv = s_r.gw_diag;
        default: rdv = '0;
      endcase
    end
    for (int n = 0; n < vgdr_pkg::NODES; n++)
    begin
      if (s_r.page == 8'(n + 1)) // see [RQ17]
      begin
        case (addr)
          vgdr_pkg::A_PAGE: rdv = {8'h00, s_r.page};
          vgdr_pkg::A_FLASH_CNT: rdv = s_r.node[n].fcnt;
          vgdr_pkg::A_NODE_DIAG: rdv = s_r.node[n].diag;
          vgdr_pkg::A_GLOB_CMD: rdv = s_r.node[n].cmd;
          vgdr_pkg::A_NODE_PROD: rdv = vgdr_pkg::NODE_PROD_CODE; // see [RQ16]
          vgdr_pkg::A_NODE_SCR: rdv = s_r.node[n].scr;
          vgdr_pkg::A_NODE_LOT_LO: rdv = i_node[n].lot_lo;
          vgdr_pkg::A_NODE_LOT_HI: rdv = i_node[n].lot_hi;
          default: rdv = '0;
        endcase
      end
    end
  end

  // Next-state of all system-domain registers
  always_comb
  begin
    s_nxt = s_r;
    cnd = '0;
    keep = '0;
    nd = '0;
    cmdv = '0;
    gset = '0;
    any_done = 1'b0;
    any_alarm = 1'b0;
    node_wr = 1'b0;
    s_nxt.cs_sync = {s_r.cs_sync[1:0], i_cs_n};
    s_nxt.tog_sync = {s_r.tog_sync[1:0], lw_r.tog};
    s_nxt.part_sync = {s_r.part_sync[0], lw_r.partial};
    if (is_rd)
      s_nxt.rd = rdv;
    if (is_wr && addr == vgdr_pkg::A_PAGE && !lw_r.word.hi)
      s_nxt.page = lw_r.word.data;

    for (int n = 0; n < vgdr_pkg::NODES; n++)
    begin
      cnd = '0;
      cnd[vgdr_pkg::B_SYS_ALARM] = i_node[n].sys_alarm; // see [RQ8]
      cnd[vgdr_pkg::B_ALM2_Y] = i_node[n].alm_y2; // see [RQ13]
      cnd[vgdr_pkg::B_ALM2_X] = i_node[n].alm_x2;
      cnd[vgdr_pkg::B_ALM1_Y] = i_node[n].alm_y1;
      cnd[vgdr_pkg::B_ALM1_X] = i_node[n].alm_x1;
      cnd[vgdr_pkg::B_REC_INTR] = i_node[n].rec_intr;
      cnd[vgdr_pkg::B_FLASH_UPD] = i_node[n].flash_upd_fail;
      cnd[vgdr_pkg::B_SUP_HI] = i_node[n].supply > vgdr_pkg::SUP_HI_CODE; // see [RQ10]
      cnd[vgdr_pkg::B_SUP_LO] = i_node[n].supply < vgdr_pkg::SUP_LO_CODE;
      // A live condition beats the clear command
      keep = s_r.node[n].cmd[vgdr_pkg::CMD_CLR_DIAG] ? '0 : s_r.node[n].diag; // see [RQ4]
      nd = (cnd | keep) & vgdr_pkg::NODE_LATCH_MASK; // see [RQ3]
      if (i_node[n].cmd_done && s_r.node[n].cmd[vgdr_pkg::CMD_SELF_TEST])
        nd[vgdr_pkg::B_SELFTEST] = i_node[n].st_fail; // see [RQ12]
      if (i_node[n].cmd_done && s_r.node[n].cmd[vgdr_pkg::CMD_FLASH_TEST])
        nd[vgdr_pkg::B_FLASH_FAIL] = i_node[n].ck_fail; // see [RQ11]
      nd = nd | ((i_node[n].alm_latch_en ? (cnd | keep) : cnd) & vgdr_pkg::NODE_ALM_MASK); // see [RQ5]
      nd[vgdr_pkg::B_SYS_ALARM] = cnd[vgdr_pkg::B_SYS_ALARM];
      s_nxt.node[n].diag = nd & vgdr_pkg::NODE_DIAG_MASK; // see [RQ19]

      node_wr = is_wr && (s_r.page == 8'(n + 1));
      cmdv = i_node[n].cmd_done ? '0 : s_r.node[n].cmd; // see [RQ18]
      cmdv[vgdr_pkg::CMD_CLR_DIAG] = 1'b0;
      if (node_wr && addr == vgdr_pkg::A_GLOB_CMD)
        cmdv = cmdv | wbits;
      s_nxt.node[n].cmd = cmdv;
      if (node_wr && addr == vgdr_pkg::A_NODE_SCR)
        s_nxt.node[n].scr = merge(s_r.node[n].scr, lw_r.word); // see [RQ15]
      s_nxt.node[n].fcnt = s_r.node[n].fcnt + 16'(i_node[n].flash_wr); // see [RQ14]
      gset[vgdr_pkg::B_NEW_DATA + n] = i_node[n].new_data; // see [RQ6]
      any_done = any_done | i_node[n].cmd_done;
      any_alarm = any_alarm | i_node[n].sys_alarm;
    end

    gset[vgdr_pkg::B_SYS_ALARM] = i_gw.sys_alarm | any_alarm; // see [RQ8]
    gset[vgdr_pkg::B_CMD_DONE] = any_done; // see [RQ7]
    gset[vgdr_pkg::B_FLASH_FAIL] = i_gw.ck_fail; // see [RQ11]
    gset[vgdr_pkg::B_SPI_ERR] = frame_end & s_r.part_sync[1]; // see [RQ9]
    gset[vgdr_pkg::B_FLASH_UPD] = i_gw.flash_upd_fail;
    gset[vgdr_pkg::B_SUP_HI] = i_gw.supply > vgdr_pkg::SUP_HI_CODE; // see [RQ10]
    gset[vgdr_pkg::B_SUP_LO] = i_gw.supply < vgdr_pkg::SUP_LO_CODE;
    // Read clears the gateway flags, but a flag raised in that cycle survives
    if (is_rd && s_r.page == vgdr_pkg::PAGE_GW && addr == vgdr_pkg::A_GW_DIAG)
      s_nxt.gw_diag = gset & vgdr_pkg::GW_DIAG_MASK; // see [RQ3]
    else
      s_nxt.gw_diag = (gset | s_r.gw_diag) & vgdr_pkg::GW_DIAG_MASK; // see [RQ19]
    s_nxt.gw_fcnt = s_r.gw_fcnt + 16'(i_gw.flash_wr); // see [RQ14]
    if (is_wr && s_r.page == vgdr_pkg::PAGE_GW && addr == vgdr_pkg::A_OUT_CTRL)
      s_nxt.out_ctrl = merge(s_r.out_ctrl, lw_r.word) & vgdr_pkg::OUT_CTRL_MASK; // see [RQ19]

    s_nxt.do_a = pin_level(s_r.out_ctrl[vgdr_pkg::OC_FN_A +: 2], // see [RQ1]
                           s_r.out_ctrl[vgdr_pkg::OC_POL_A], i_gw.gp_level[0],
                           gset[vgdr_pkg::B_SYS_ALARM], i_gw.busy);
    s_nxt.do_b = pin_level(s_r.out_ctrl[vgdr_pkg::OC_FN_B +: 2],
                           s_r.out_ctrl[vgdr_pkg::OC_POL_B], i_gw.gp_level[1],
                           gset[vgdr_pkg::B_SYS_ALARM], i_gw.busy);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      s_r <= '0;
      s_r.cs_sync <= vgdr_pkg::CS_IDLE;
      s_r.out_ctrl <= vgdr_pkg::OUT_CTRL_RST; // see [RQ2]
      s_r.do_a <= vgdr_pkg::PIN_IDLE;
      s_r.do_b <= vgdr_pkg::PIN_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  always_comb
  begin
    for (int n = 0; n < vgdr_pkg::NODES; n++)
      o_node_cmd[n] = s_r.node[n].cmd;
  end

  assign o_digital_out_a = s_r.do_a;
  assign o_digital_out_b = s_r.do_b;

  sequence s_bad_end;
    s_r.cs_sync[1] && !s_r.cs_sync[2] && s_r.part_sync[1];
  endsequence

  sequence s_selftest_done;
    s_r.node[0].cmd[vgdr_pkg::CMD_SELF_TEST] && i_node[0].cmd_done;
  endsequence

  sequence s_flash_test_done;
    s_r.node[1].cmd[vgdr_pkg::CMD_FLASH_TEST] && i_node[1].cmd_done;
  endsequence

  // Output control and pins
  a_out_ctrl_reset: assert property (@(posedge i_clk) i_sys_rst |=> // see [RQ2]
    s_r.out_ctrl == vgdr_pkg::OUT_CTRL_RST && o_digital_out_a == vgdr_pkg::PIN_IDLE &&
    o_digital_out_b == vgdr_pkg::PIN_IDLE)
    else $error("output control reset value wrong");
  a_pin_unused_fn: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ1]
    s_r.out_ctrl[vgdr_pkg::OC_FN_A +: 2] == vgdr_pkg::FN_NONE |=>
    o_digital_out_a == !$past(s_r.out_ctrl[vgdr_pkg::OC_POL_A]))
    else $error("unused function does not show inactive level");
  a_out_high_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ19]
    is_wr && s_r.page == vgdr_pkg::PAGE_GW && addr == vgdr_pkg::A_OUT_CTRL && lw_r.word.hi
    |=> $stable(s_r.out_ctrl))
    else $error("high byte write changed output control");

  // Node flags, watched on the nodes that carry traffic
  a_diag_persist: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ4]
    i_node[1].rec_intr |=> s_r.node[1].diag[vgdr_pkg::B_REC_INTR] ##1
    (!o_node_cmd[1][vgdr_pkg::CMD_CLR_DIAG] || $past(is_wr)))
    else $error("record interrupt flag not set");
  a_alarm_follow: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ5]
    !i_node[1].alm_latch_en && !i_node[1].alm_x1 |=> !s_r.node[1].diag[vgdr_pkg::B_ALM1_X])
    else $error("unlatched alarm flag stuck");
  a_alarm_latch: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ5]
    i_node[1].alm_latch_en && s_r.node[1].diag[vgdr_pkg::B_ALM2_Y] &&
    !s_r.node[1].cmd[vgdr_pkg::CMD_CLR_DIAG] |=> s_r.node[1].diag[vgdr_pkg::B_ALM2_Y])
    else $error("latched alarm flag lost");
  a_sys_alarm_node: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ8]
    !i_sys_rst |=> s_r.node[1].diag[vgdr_pkg::B_SYS_ALARM] == $past(i_node[1].sys_alarm))
    else $error("node system alarm does not follow");
  a_selftest_result: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ12]
    s_selftest_done |=> s_r.node[0].diag[vgdr_pkg::B_SELFTEST] == $past(i_node[0].st_fail))
    else $error("self-test result not stored");
  a_flash_test_result: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ11]
    s_flash_test_done |=> s_r.node[1].diag[vgdr_pkg::B_FLASH_FAIL] == $past(i_node[1].ck_fail))
    else $error("checksum result not stored");
  a_clear_self: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ18]
    s_r.node[1].cmd[vgdr_pkg::CMD_CLR_DIAG] |=>
    !s_r.node[1].cmd[vgdr_pkg::CMD_CLR_DIAG] || $past(is_wr))
    else $error("clear command did not self-clear");
  a_cmd_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ18]
    s_r.node[0].cmd[vgdr_pkg::CMD_SELF_TEST] && !i_node[0].cmd_done |=>
    s_r.node[0].cmd[vgdr_pkg::CMD_SELF_TEST])
    else $error("pending command dropped early");
  a_scratch_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ15]
    !is_wr |=> $stable(s_r.node[2].scr))
    else $error("scratch changed without a write");

  // Gateway flags and counters
  for (genvar g = 0; g < vgdr_pkg::NODES; g++)
  begin : g_new_data
    a_new_data_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ6]
      i_node[g].new_data |=> s_r.gw_diag[vgdr_pkg::B_NEW_DATA + g])
      else $error("new data flag missing");
  end
  a_cmd_done_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ7]
    i_node[1].cmd_done |=> s_r.gw_diag[vgdr_pkg::B_CMD_DONE] &&
    (s_r.node[1].cmd == '0 || $past(is_wr)))
    else $error("completion not reported");
  a_gw_sys_alarm: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ8]
    i_gw.sys_alarm || i_node[1].sys_alarm |=> s_r.gw_diag[vgdr_pkg::B_SYS_ALARM])
    else $error("gateway system alarm missing");
  a_bad_frame: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ9]
    s_bad_end |=> s_r.gw_diag[vgdr_pkg::B_SPI_ERR])
    else $error("bad clock count not flagged");
  a_supply_high: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ10]
    i_gw.supply > vgdr_pkg::SUP_HI_CODE |=> s_r.gw_diag[vgdr_pkg::B_SUP_HI])
    else $error("supply high not flagged");
  a_supply_low: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ10]
    i_gw.supply < vgdr_pkg::SUP_LO_CODE |=> s_r.gw_diag[vgdr_pkg::B_SUP_LO])
    else $error("supply low not flagged");
  a_flash_count: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ14]
    i_gw.flash_wr |=> s_r.gw_fcnt == 16'($past(s_r.gw_fcnt) + 16'h0001))
    else $error("flash counter did not step");
  a_count_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ14]
    !i_gw.flash_wr |=> $stable(s_r.gw_fcnt))
    else $error("flash counter moved without a write");
  a_page_unmapped: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ17]
    is_rd && s_r.page > 8'(vgdr_pkg::NODES) |=> s_r.rd == '0)
    else $error("unmapped page read not zero");
  a_unused_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [RQ19]
    (s_r.gw_diag & ~vgdr_pkg::GW_DIAG_MASK) == '0 &&
    (s_r.node[1].diag & ~vgdr_pkg::NODE_DIAG_MASK) == '0 &&
    (s_r.out_ctrl & ~vgdr_pkg::OUT_CTRL_MASK) == '0)
    else $error("unused bit set");
endmodule : vgdr_regs

// file: verification/diag_status_ident_regs_tb.sv
// Self-checking bench for the diagnostic, identification and output registers
`timescale 1ns/1ps
module diag_status_ident_regs_tb;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic sclk, cs_n, din, dout, pa, pb;
  vgdr_pkg::vgdr_gw_in_t gw;
  vgdr_pkg::vgdr_node_in_t [5:0] nd;
  logic [5:0][15:0] ncmd;
  logic [15:0] rv, lo [8], hi [8], pr [8];
  int error_cnt = 0;
  int num_checks = 0;
  int k, p, v;

  always #20 i_clk = ~i_clk;

  vgdr_regs uut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .o_dout(dout), .o_dout_oe(), .i_gw(gw), .i_node(nd), .o_node_cmd(ncmd),
    .o_digital_out_a(pa), .o_digital_out_b(pb)
  );

  vgdr_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din), .i_dout(dout));

  task automatic chk_reg(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_pin(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_pin

  task automatic wr(input logic [6:0] a, input logic h, input logic [7:0] d);
    logic [15:0] r;
    host.xfer({1'b1, a[6:1], h, d}, 16, r);
  endtask : wr

  // A read reply comes back during the following frame
  task automatic rdc(input logic [6:0] a, input string nm, input logic [15:0] e);
    logic [15:0] q;
    host.xfer({1'b0, a[6:1], 9'h000}, 16, q);
    host.xfer(16'h0000, 16, q);
    chk_reg(nm, e, q);
  endtask : rdc

  function automatic logic pe(input logic [1:0] fn, input logic pol, input logic gp);
    logic act;
    act = fn == 2'h0 ? gp : fn == 2'h1 ? gw.sys_alarm : fn == 2'h2 ? gw.busy : 1'b0;
    return pol ? act : ~act;
  endfunction : pe

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // Cuts a hang short
  initial
  begin
    #3000000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    void'($urandom(32'h5F64));
    gw = '0;
    nd = '0;
    for (k = 0; k < 8; k++)
    begin
      lo[k] = k < 7 ? 16'($urandom) : 16'h0000;
      hi[k] = k < 7 ? 16'($urandom) : 16'h0000;
      pr[k] = k == 0 ? vgdr_pkg::GW_PROD_CODE : k < 7 ? vgdr_pkg::NODE_PROD_CODE : 16'h0000;
    end
    gw.lot_lo = lo[0];
    gw.lot_hi = hi[0];
    gw.serial = 16'($urandom);
    gw.supply = 16'h1D4C;
    for (k = 0; k < 6; k++)
    begin
      nd[k].lot_lo = lo[k + 1];
      nd[k].lot_hi = hi[k + 1];
      nd[k].supply = 16'h1D4C;
    end
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (3) @(negedge i_clk);
    chk_pin("digital_out_a", 1'b1, pa);
    chk_pin("digital_out_b", 1'b1, pb);
    rdc(7'h2A, "output_pin_control", 16'h0008);
    rdc(7'h2C, "gateway_diag_status", 16'h0000);

    // Gateway flags latch, clear on read
    k = $urandom_range(5);
    @(negedge i_clk);
    gw.supply = 16'h202F;
    nd[k].new_data = 1'b1;
    @(negedge i_clk);
    nd[k].new_data = 1'b0;
    host.xfer(16'h0000, 15, rv);
    rdc(7'h2C, "gateway_diag_status", 16'h000A | (16'h0100 << k));
    rdc(7'h2C, "gateway_diag_status", 16'h0002);
    for (k = 0; k < 4; k++)
    begin
      @(negedge i_clk);
      gw.supply = k < 2 ? 16'h11C1 : 16'h202E;
      rdc(7'h2C, "gateway_diag_status", k == 0 ? 16'h0003 : k == 3 ? 16'h0000 : 16'h0001);
    end

    // Self-test on node 1, flash checksum on node 2; both fail inputs high
    for (k = 0; k < 2; k++)
    begin
      v = k ? 5 : 2;
      wr(7'h00, 1'b0, 8'(k + 1));
      wr(7'h36, 1'b0, 8'(1 << v));
      chk_reg("node_command", 16'(1 << v), ncmd[k]);
      @(negedge i_clk);
      nd[k].cmd_done = 1'b1;
      nd[k].st_fail = 1'b1;
      nd[k].ck_fail = 1'b1;
      @(negedge i_clk);
      nd[k].cmd_done = 1'b0;
      nd[k].st_fail = 1'b0;
      nd[k].ck_fail = 1'b0;
      @(negedge i_clk);
      chk_reg("node_command", 16'h0000, ncmd[k]);
      rdc(7'h34, "node_diag_status", 16'(1 << (k ? 6 : 5)));
      wr(7'h00, 1'b0, 8'h00);
      rdc(7'h2C, "gateway_diag_status", 16'h0080);
    end

    // Node 2: clear while conditions persist, then latched alarms
    @(negedge i_clk);
    nd[1].rec_intr = 1'b1;
    nd[1].alm_x1 = 1'b1;
    nd[1].sys_alarm = 1'b1;
    rdc(7'h2C, "gateway_diag_status", 16'h4000);
    wr(7'h00, 1'b0, 8'h02);
    wr(7'h36, 1'b0, 8'h10);
    rdc(7'h34, "node_diag_status", 16'h4110);
    @(negedge i_clk);
    nd[1].rec_intr = 1'b0;
    nd[1].alm_x1 = 1'b0;
    nd[1].sys_alarm = 1'b0;
    // Alarm must drop while latching is off before latching is turned on
    @(negedge i_clk);
    nd[1].alm_latch_en = 1'b1;
    nd[1].alm_y2 = 1'b1;
    @(negedge i_clk);
    nd[1].alm_y2 = 1'b0;
    rdc(7'h34, "node_diag_status", 16'h1010);

    // Every page: counters, identification and scratch; page 7 is unmapped
    for (p = 0; p < 8; p++)
    begin
      wr(7'h00, 1'b0, 8'(p));
      for (k = 0; k <= p && p < 7; k++)
      begin
        @(negedge i_clk);
        if (p == 0)
          gw.flash_wr = 1'b1;
        else
          nd[p - 1].flash_wr = 1'b1;
        @(negedge i_clk);
        gw.flash_wr = 1'b0;
        if (p > 0)
          nd[p - 1].flash_wr = 1'b0;
      end
      rdc(7'h04, "flash_write_count", p < 7 ? 16'(p + 1) : 16'h0000);
      rdc(p ? 7'h68 : 7'h1A, "lot_code_low", lo[p]);
      rdc(p ? 7'h6A : 7'h1C, "lot_code_high", hi[p]);
      rdc(p ? 7'h48 : 7'h16, "product_code", pr[p]);
      rdc(7'h24, "gateway_serial_number", p == 0 ? gw.serial : 16'h0000);
      rdc(7'h64, "node_user_scratch", 16'h0000);
      rv = 16'($urandom);
      wr(7'h64, 1'b0, rv[7:0]);
      wr(7'h64, 1'b1, rv[15:8]);
      rdc(7'h64, "node_user_scratch", (p > 0 && p < 7) ? rv : 16'h0000);
    end

    // Every function and polarity setting of both pins
    wr(7'h00, 1'b0, 8'h00);
    for (v = 0; v < 64; v++)
    begin
      @(negedge i_clk);
      gw.busy = 1'($urandom);
      gw.gp_level = 2'($urandom);
      gw.sys_alarm = 1'($urandom);
      rv = 16'(v);
      wr(7'h2A, 1'b0, rv[7:0]);
      chk_pin("digital_out_a", pe(rv[3:2], rv[0], gw.gp_level[0]), pa);
      chk_pin("digital_out_b", pe(rv[5:4], rv[1], gw.gp_level[1]), pb);
    end
    wr(7'h2A, 1'b1, 8'hFF);
    rdc(7'h2A, "output_pin_control", 16'h003F);
    finish_test();
  end
endmodule : diag_status_ident_regs_tb

// file: verification/vgdr_host.sv
// Host model that frames 16-bit words on the serial link in mode 3
`timescale 1ns/1ps
module vgdr_host (
  // Serial link towards the device
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  // Reply from the device
  input wire logic i_dout
);
  initial
  begin
    o_sclk = 1'b1;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end

  // Clock runs only inside a frame, 48 ns period; n below 16 makes a short frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    #7;
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #24 o_sclk = 1'b0;
      o_din = w[15 - i];
      #24 o_sclk = 1'b1;
      r = {r[14:0], i_dout};
    end
    #24 o_cs_n = 1'b1;
    // Released line must not keep showing the last bit
    o_din = ~o_din;
    // Gap above 320 ns so the reply settles
    #400;
  endtask : xfer
endmodule : vgdr_host
